// ---- rtl/xlt_cycle_pad.sv ----
`timescale 1ns/10ps
`default_nettype none
// Counts out the remaining cycles of a timing budget, one per clock
module xlt_cycle_pad
  import xlt_pkg::*;
#(
  parameter int unsigned W = xlt_pkg::TIME_W
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              busy
);
  logic [W-1:0] left_q;
  assign busy = (left_q != '0);
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      left_q <= '0;
    else if (load)
      left_q <= count;
    else if (busy)
      left_q <= left_q - 1'b1;
  end
endmodule // xlt_cycle_pad
`default_nettype wire

// ---- rtl/xlt_engine.sv ----
`timescale 1ns/10ps
`default_nettype none
// Function
// - Table address is base plus zero-extended target byte.
// - Read table byte into the translation result byte register.
// - Zero flag set when loaded value is zero, else cleared.
// - Memory is only read, never written.
// - Descending scan decrements the string pointer by one per element.
// - Step and ascending scan increment the string pointer by one.
// - Counter decrements by one after each element.
// - Repeat until nonzero value loaded or counter reaches zero.
// - One repeating instruction handles 1 to 65536 elements.
// - Count-expired flag set when decremented counter is zero.
// - Table base register is never changed.
// - Interrupt accepted between iterations of repeating variants.
// - Save instruction start address before accepting interrupt.
// - Each accepted interrupt adds seven cycles.
// - Single step decode, 25 cycles in both modes.
// - Pointer and base are words nonsegmented, pairs segmented.
// - Ascending scan decode and 11 + 14n cycle timing.
module xlt_engine
  import xlt_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire logic                   start,
  input  wire logic [15:0]            instr_w1,
  input  wire logic [15:0]            instr_w2,
  input  wire logic                   segmented,
  input  wire logic [xlt_pkg::ADDR_W-1:0] instr_pc,
  input  wire logic [xlt_pkg::ADDR_W-1:0] string_pointer_in,
  input  wire logic [xlt_pkg::ADDR_W-1:0] table_base_in,
  input  wire logic [xlt_pkg::CNT_W-1:0]  count_in,
  input  wire logic                   irq_req,
  input  wire logic                   mem_ack,
  input  wire logic [7:0]             mem_rdata,
  output logic                        mem_rd,
  output logic [xlt_pkg::ADDR_W-1:0]  mem_addr,
  output logic                        mem_wr,
  output logic                        busy,
  output logic                        done,
  output logic                        illegal,
  output logic                        irq_take,
  output logic [xlt_pkg::ADDR_W-1:0]  saved_pc,
  output logic [xlt_pkg::ADDR_W-1:0]  string_pointer_register,
  output logic [xlt_pkg::ADDR_W-1:0]  table_base_register,
  output logic [xlt_pkg::CNT_W-1:0]   count_out,
  output logic [7:0]                  translation_result_byte,
  output logic                        flag_zero,
  output logic                        flag_overflow
);
  import xlt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic logic [ADDR_W-1:0] seg_addr(input logic [ADDR_W-1:0] a, input logic seg);
    // Nonsegmented mode uses only a 16-bit word register
    seg_addr = seg ? a : {{(ADDR_W-16){1'b0}}, a[15:0]};
  endfunction

  function automatic logic [ADDR_W-1:0] seg_step(input logic [ADDR_W-1:0] a, input logic seg,
                                                 input logic down);
    logic [15:0] off;
    off = down ? (a[15:0] - 16'h0001) : (a[15:0] + 16'h0001);
    // Address arithmetic wraps within the offset; segment number untouched
    seg_step = seg ? {a[ADDR_W-1:16], off} : {{(ADDR_W-16){1'b0}}, off};
  endfunction

  wire logic       hdr_ok     = (instr_w1[15:8] == OP_PREFIX) && (instr_w1[7:4] != 4'h0) &&
                                (instr_w2[15:12] == W2_HIGH_NIBBLE) && (instr_w2[7:4] != 4'h0);
  wire logic       dec_down   = hdr_ok && (instr_w1[3:0] == SUB_SCAN_DOWN) &&
                                (instr_w2[3:0] == W2_REPEAT_LOW);
  wire logic       dec_step   = hdr_ok && (instr_w1[3:0] == SUB_STEP_UP) &&
                                (instr_w2[3:0] == W2_SINGLE_LOW);
  wire logic       dec_up     = hdr_ok && (instr_w1[3:0] == SUB_SCAN_UP) &&
                                (instr_w2[3:0] == W2_REPEAT_LOW);
  wire variant_t   dec_var    = dec_down ? VAR_SCAN_DOWN : dec_step ? VAR_STEP_UP :
                                dec_up ? VAR_SCAN_UP : VAR_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // State
  state_t              state_q, state_d;
  variant_t            var_q;
  logic                seg_q;
  logic [ADDR_W-1:0]   ptr_q, base_q, pc_q;
  logic [CNT_W-1:0]    cnt_q;
  logic [7:0]          rh_q;
  logic                z_q, v_q;
  logic                irq_q;
  logic                pad_load;
  logic [TIME_W-1:0]   pad_count;
  logic                pad_busy;

  // Target byte is taken off the bus on the edge that launches the table read
  wire logic [7:0]        idx_byte  = (state_q == ST_WAIT_STR) ? mem_rdata : rh_q;
  wire logic [ADDR_W-1:0] tbl_addr  = seg_q ?
                                      {base_q[ADDR_W-1:16], base_q[15:0] + {8'h00, idx_byte}} :
                                      {{(ADDR_W-16){1'b0}}, base_q[15:0] + {8'h00, idx_byte}};
  // ptr_q loads on the same edge as the first string read, so that read uses the input
  wire logic [ADDR_W-1:0] str_addr  = (state_q == ST_IDLE) ? seg_addr(string_pointer_in, segmented) : ptr_q;
  // counter step, zero wraps to 65535 first
  wire logic [CNT_W-1:0]  cnt_dec   = cnt_q - 1'b1;
  wire logic              cnt_zero  = (cnt_dec == '0);
  wire logic              val_zero  = (mem_rdata == 8'h00);
  wire logic              repeating = (var_q != VAR_STEP_UP);
  wire logic              finish    = !repeating || !z_q || v_q;
  wire logic              str_phase = (state_q == ST_RD_STR);
  wire logic              step_ok   = (state_q == ST_UPDATE);

  xlt_cycle_pad #(
    .W (TIME_W)
  ) u_pad (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .load    (pad_load),
    .count   (pad_count),
    .busy    (pad_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  // Budget per element: 4 access cycles plus padding; pad reaches 14 (or 25 / 11 extra)
  always_comb
  begin
    state_d   = state_q;
    pad_load  = 1'b0;
    pad_count = '0;
    unique case (state_q)
      ST_IDLE:     if (start && dec_var != VAR_NONE) state_d = ST_RD_STR;
      ST_RD_STR:   state_d = ST_WAIT_STR;
      ST_WAIT_STR: if (mem_ack) state_d = ST_RD_TBL;
      ST_RD_TBL:   state_d = ST_WAIT_TBL;
      ST_WAIT_TBL: if (mem_ack) state_d = ST_UPDATE;
      ST_UPDATE:
      begin
        state_d  = ST_PAD;
        pad_load = 1'b1;
        pad_count = TIME_W'(CYC_REP_ELEM - 6);
      end
      ST_PAD:
        if (!pad_busy)
        begin
          if (finish)
          begin
            state_d   = ST_DONE;
            pad_load  = 1'b1;
            pad_count = repeating ? TIME_W'(CYC_REP_BASE - 1) : TIME_W'(CYC_SINGLE - CYC_REP_ELEM - 1);
          end
          else if (irq_req)
          begin
            state_d   = ST_IRQ;
            pad_load  = 1'b1;
            pad_count = TIME_W'(CYC_IRQ_EXTRA - 1);
          end
          else
            state_d = ST_RD_STR;
        end
      ST_IRQ:      if (!pad_busy) state_d = ST_IDLE;
      ST_DONE:     if (!pad_busy) state_d = ST_IDLE;
      default:     state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      var_q  <= VAR_NONE;
      seg_q  <= 1'b0;
      ptr_q  <= '0;
      base_q <= '0;
      pc_q   <= '0;
      cnt_q  <= '0;
      rh_q   <= 8'h00;
      z_q    <= 1'b0;
      v_q    <= 1'b0;
      irq_q  <= 1'b0;
    end
    else
    begin
      irq_q <= (state_q == ST_PAD) && (state_d == ST_IRQ);
      if (state_q == ST_IDLE && start && dec_var != VAR_NONE)
      begin
        var_q  <= dec_var;
        seg_q  <= segmented;
        ptr_q  <= seg_addr(string_pointer_in, segmented);
        base_q <= seg_addr(table_base_in, segmented);
        pc_q   <= instr_pc;
        cnt_q  <= count_in;
      end
      // Target byte parked in rh_q until the table read replaces it
      if (state_q == ST_WAIT_STR && mem_ack)
        rh_q <= mem_rdata;
      if (state_q == ST_WAIT_TBL && mem_ack)
      begin
        rh_q <= mem_rdata;
        z_q  <= val_zero;
      end
      if (step_ok)
      begin
        ptr_q <= seg_step(ptr_q, seg_q, var_q == VAR_SCAN_DOWN);
        cnt_q <= cnt_dec;
        v_q   <= cnt_zero;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      mem_rd   <= 1'b0;
      mem_wr   <= 1'b0;
      mem_addr <= '0;
      busy     <= 1'b0;
      done     <= 1'b0;
      illegal  <= 1'b0;
      saved_pc <= '0;
    end
    else
    begin
      mem_rd   <= (state_d == ST_RD_STR) || (state_d == ST_RD_TBL);
      mem_wr   <= 1'b0;
      mem_addr <= (state_d == ST_RD_TBL) ? tbl_addr : str_addr;
      busy     <= (state_d != ST_IDLE);
      done     <= (state_q == ST_DONE) && !pad_busy;
      illegal  <= (state_q == ST_IDLE) && start && (dec_var == VAR_NONE);
      if (state_q == ST_PAD && state_d == ST_IRQ)
        saved_pc <= pc_q;
    end
  end

  assign irq_take                = irq_q;
  assign string_pointer_register = ptr_q;
  assign table_base_register     = base_q;
  assign count_out               = cnt_q;
  assign translation_result_byte = rh_q;
  assign flag_zero               = z_q;
  assign flag_overflow           = v_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_no_mem_write: assert property (!mem_wr)
    else $error("memory written");
  a_zero_flag_load: assert property (
    (state_q == ST_WAIT_TBL && mem_ack) |=> flag_zero == ($past(mem_rdata) == 8'h00))
    else $error("zero flag wrong");
  a_result_load: assert property (
    (state_q == ST_WAIT_TBL && mem_ack) |=> translation_result_byte == $past(mem_rdata))
    else $error("result not loaded");
  a_count_step: assert property (
    step_ok |=> count_out == $past(count_out) - 16'h0001)
    else $error("counter step wrong");
  a_vflag_set: assert property (
    step_ok |=> flag_overflow == (count_out == 16'h0000))
    else $error("count flag wrong");
  a_ptr_down: assert property (
    (step_ok && var_q == VAR_SCAN_DOWN) |=>
      string_pointer_register[15:0] == $past(string_pointer_register[15:0]) - 16'h0001)
    else $error("pointer not decremented");
  a_ptr_up: assert property (
    (step_ok && var_q != VAR_SCAN_DOWN) |=>
      string_pointer_register[15:0] == $past(string_pointer_register[15:0]) + 16'h0001)
    else $error("pointer not incremented");
  a_base_stable: assert property (
    busy && $past(busy) |-> $stable(table_base_register))
    else $error("base changed");
  a_tbl_addr: assert property (
    (state_q == ST_RD_TBL) |-> mem_addr[15:0] == table_base_register[15:0] + {8'h00, translation_result_byte})
    else $error("table address wrong");
  a_string_addr: assert property (
    str_phase |-> mem_rd && mem_addr == string_pointer_register)
    else $error("string read wrong");
  a_stop_nonzero: assert property (
    (state_q == ST_PAD && !pad_busy && repeating && !flag_zero) |=> state_q == ST_DONE)
    else $error("scan did not stop");
  a_stop_count: assert property (
    (state_q == ST_PAD && !pad_busy && flag_overflow) |=> state_q == ST_DONE)
    else $error("count expiry ignored");
  a_step_single: assert property (
    (state_q == ST_PAD && !pad_busy && var_q == VAR_STEP_UP) |=> state_q == ST_DONE)
    else $error("single step repeated");
  a_irq_pc: assert property (
    (state_q == ST_PAD && state_d == ST_IRQ) |=> saved_pc == pc_q && irq_take)
    else $error("resume point not saved");
  a_irq_seven: assert property (
    $rose(irq_take) |-> busy [*7] ##1 !busy)
    else $error("interrupt penalty wrong");

  c_scan_done:  cover property (done && var_q == VAR_SCAN_DOWN);
  c_found:      cover property (done && !flag_zero && !flag_overflow);
  c_irq:        cover property (irq_take);
  c_step:       cover property (done && var_q == VAR_STEP_UP);
  c_illegal:    cover property (illegal);
endmodule // xlt_engine
`default_nettype wire

// ---- rtl/xlt_pkg.sv ----
package xlt_pkg;
  // Instruction encoding
  localparam logic [7:0] OP_PREFIX      = 8'hb8;
  localparam logic [3:0] SUB_SCAN_DOWN  = 4'he;
  localparam logic [3:0] SUB_STEP_UP    = 4'h2;
  localparam logic [3:0] SUB_SCAN_UP    = 4'h6;
  localparam logic [3:0] W2_REPEAT_LOW  = 4'he;
  localparam logic [3:0] W2_SINGLE_LOW  = 4'h0;
  localparam logic [3:0] W2_HIGH_NIBBLE = 4'h0;
  // Cycle budget
  localparam int unsigned CYC_REP_BASE  = 11;
  localparam int unsigned CYC_REP_ELEM  = 14;
  localparam int unsigned CYC_SINGLE    = 25;
  localparam int unsigned CYC_IRQ_EXTRA = 7;
  // Widths
  localparam int unsigned ADDR_W = 23;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned TIME_W = 8;
  localparam int unsigned REG_IDX_W = 4;
  typedef enum logic [1:0] {VAR_NONE, VAR_SCAN_DOWN, VAR_STEP_UP, VAR_SCAN_UP} variant_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_STR, ST_WAIT_STR, ST_RD_TBL, ST_WAIT_TBL, ST_UPDATE, ST_PAD, ST_IRQ, ST_DONE
  } state_t;
endpackage

// ---- test/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
  import xlt_pkg::*;
  typedef struct packed {
    logic [3:0] s1; logic [3:0] s2; logic sg; logic [3:0] dl;
    logic [15:0] p; logic [15:0] c; logic [15:0] ep; logic [15:0] ec; logic [7:0] er; logic ez; logic ev;
  } row_t;
  logic              clk_sys, resetn, start, segmented, irq_req, mem_ack, mem_rd, mem_wr, wr_seen;
  logic              busy, done, illegal, irq_take, flag_zero, flag_overflow;
  logic [15:0]       instr_w1, instr_w2;
  logic [CNT_W-1:0]  count_in, count_out;
  logic [7:0]        mem_rdata, translation_result_byte;
  logic [3:0]        dly;
  logic [ADDR_W-1:0] instr_pc, string_pointer_in, table_base_in, mem_addr, saved_pc;
  logic [ADDR_W-1:0] string_pointer_register, table_base_register;
  int                num_errors, check_count, cyc, i, took, el, exp_cyc;
  logic [7:0]        str [7] = '{8'h00, 8'h40, 8'h80, 8'h00, 8'h80, 8'h00, 8'h7f};
  row_t              rows [6] = '{
    '{SUB_SCAN_DOWN, W2_REPEAT_LOW, 1'b0, 4'h0, 16'h4002, 16'h3, 16'h4000, 16'h1, 8'h40, 1'b0, 1'b0},
    '{SUB_SCAN_UP, W2_REPEAT_LOW, 1'b0, 4'h2, 16'h4003, 16'h3, 16'h4006, 16'h0, 8'h00, 1'b1, 1'b1},
    '{SUB_STEP_UP, W2_SINGLE_LOW, 1'b1, 4'h0, 16'h4000, 16'h2, 16'h4001, 16'h1, 8'h00, 1'b1, 1'b0},
    '{SUB_SCAN_UP, W2_REPEAT_LOW, 1'b0, 4'h0, 16'h4005, 16'h5, 16'h4007, 16'h3, 8'h7f, 1'b0, 1'b0},
    '{SUB_SCAN_DOWN, W2_REPEAT_LOW, 1'b1, 4'h1, 16'h4000, 16'h1, 16'h3fff, 16'h0, 8'h00, 1'b1, 1'b1},
    '{SUB_SCAN_UP, W2_REPEAT_LOW, 1'b0, 4'h0, 16'h4001, 16'h0, 16'h4002, 16'hffff, 8'h40, 1'b0, 1'b0}};

  xlt_engine DUT (.clk_sys, .resetn, .start, .instr_w1, .instr_w2, .segmented, .instr_pc, .string_pointer_in,
    .table_base_in, .count_in, .irq_req, .mem_ack, .mem_rdata, .mem_rd, .mem_addr, .mem_wr, .busy, .done,
    .illegal, .irq_take, .saved_pc, .string_pointer_register, .table_base_register, .count_out,
    .translation_result_byte, .flag_zero, .flag_overflow);
  xlt_mem_model mem_model (.clk_sys, .mem_rd, .mem_addr, .dly, .mem_ack, .mem_rdata);

  always #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // Distinct pointer, table and counter fields keep the outcome defined
  task automatic go(input logic [3:0] s1, s2, input logic sg, input logic [15:0] p, c);
    int n;
    while (busy === 1'b1)
      @(negedge clk_sys);
    instr_w1 = {OP_PREFIX, 4'h6, s1};
    instr_w2 = {W2_HIGH_NIBBLE, 4'h3, 4'h9, s2};
    segmented = sg;
    string_pointer_in = {7'h00, p};
    count_in = c;
    start = 1'b1;
    for (n = 0; n < 3000; n++)
    begin
      @(negedge clk_sys);
      start = 1'b0;
      if (done === 1'b1 || irq_take === 1'b1 || illegal === 1'b1)
        break;
    end
    took = n;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    cyc++;
    if (resetn === 1'b1 && mem_wr !== 1'b0)
      wr_seen = 1'b1;
    // Ceiling well above the few hundred cycles the tests need
    if (cyc == 20000)
    begin
      num_errors++;
      $display("unexpected at %0t: run too long", $time);
      complete_run();
    end
  end

  initial
  begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    start = 1'b0;
    segmented = 1'b0;
    irq_req = 1'b0;
    dly = 4'h0;
    instr_w1 = 16'h0;
    instr_w2 = 16'h0;
    count_in = 16'h0;
    instr_pc = 23'h000200;
    string_pointer_in = 23'h0;
    table_base_in = 23'h001000;
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    wr_seen = 1'b0;
    for (i = 0; i < 256; i++)
      mem_model.mem[16'(16'h1000 + i)] = {1'b0, i[6:0]};
    for (i = 0; i < 7; i++)
      mem_model.mem[16'(16'h4000 + i)] = str[i];
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    check({busy, done, count_out, translation_result_byte, flag_zero, flag_overflow} === '0, "reset values");
    for (i = 0; i < 6; i++)
    begin
      dly = rows[i].dl;
      go(rows[i].s1, rows[i].s2, rows[i].sg, rows[i].p, rows[i].c);
      check(done === 1'b1, "no completion");
      check(string_pointer_register === {7'h00, rows[i].ep}, "pointer");
      check(count_out === rows[i].ec, "counter");
      check(translation_result_byte === rows[i].er, "result byte");
      check(flag_zero === rows[i].ez, "zero flag");
      check(flag_overflow === rows[i].ev, "count flag");
      check(table_base_register === table_base_in, "table base");
      // Each memory wait state lengthens both reads of every element
      el = 16'(rows[i].c - rows[i].ec);
      exp_cyc = (rows[i].s2 == W2_SINGLE_LOW) ? CYC_SINGLE : CYC_REP_BASE + CYC_REP_ELEM * el;
      check(took == exp_cyc + 2 * el * rows[i].dl, "cycle count");
      $display("row %0d finished", i);
    end
    go(4'h5, W2_REPEAT_LOW, 1'b0, 16'h4000, 16'h1);
    check(illegal === 1'b1 && done === 1'b0, "bad first word");
    go(SUB_STEP_UP, W2_REPEAT_LOW, 1'b0, 16'h4000, 16'h1);
    check(illegal === 1'b1 && done === 1'b0, "bad second word");
    $display("decode test finished");
    irq_req = 1'b1;
    go(SUB_SCAN_UP, W2_REPEAT_LOW, 1'b0, 16'h4003, 16'h3);
    irq_req = 1'b0;
    check(irq_take === 1'b1 && saved_pc === instr_pc, "resume point");
    check(count_out === 16'h2 && string_pointer_register === 23'h004004, "state at interrupt");
    for (i = 0; i < 8 && busy === 1'b1; i++)
      @(negedge clk_sys);
    check(busy === 1'b0 && i == CYC_IRQ_EXTRA, "interrupt exit");
    $display("interrupt test finished");
    // Reset in mid-scan must abandon the instruction
    dly = 4'h3;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(busy === 1'b1, "scan not running");
    resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(busy === 1'b0 && count_out === 16'h0, "reset mid run");
    resetn = 1'b1;
    $display("reset test finished");
    check(wr_seen === 1'b0, "memory written");
    complete_run();
  end
endmodule // tb
`default_nettype wire

// ---- test/xlt_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Byte memory behind the engine; answers each read after a set number of cycles
module xlt_mem_model
  import xlt_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       mem_rd,
  input  wire logic [xlt_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic [3:0]                 dly,
  output logic                            mem_ack,
  output logic [7:0]                      mem_rdata
);
  logic [7:0]        mem [0:65535];
  logic [ADDR_W-1:0] addr_q;
  logic [3:0]        wait_q;
  logic              pend_q = 1'b0;

  initial
  begin
    mem_ack   = 1'b0;
    mem_rdata = 8'h5a;
  end

  // Driven on the falling edge so the engine samples settled values
  always @(negedge clk_sys)
  begin
    // Released data line flips, so a stale byte is never mistaken for an answer
    if (mem_ack)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
    if (mem_rd)
    begin
      addr_q <= mem_addr;
      wait_q <= dly;
      pend_q <= 1'b1;
    end
    else if (pend_q && wait_q == 4'h0)
    begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem[addr_q[15:0]];
      pend_q    <= 1'b0;
    end
    else if (pend_q)
      wait_q <= wait_q - 4'h1;
  end
endmodule // xlt_mem_model
`default_nettype wire
